/* common/fwdl_pkg.sv */
// constants and types shared by the firmware download and diagnostic command block
package fwdl_pkg;

  // ==========================================================================
  // command and subcommand codes
  localparam logic [7:0] CMD_DL_DMA    = 8'h93;  // firmware download over dma
  localparam logic [7:0] CMD_SELF_DIAG = 8'h90;  // self diagnostic
  localparam logic [7:0] SUB_OFFSETS   = 8'h03;  // segmented download with offsets
  localparam logic [7:0] SUB_SINGLE    = 8'h07;  // single download and save

  // ==========================================================================
  // bus constants
  localparam int         ADDR_DEC_W    = 8;      // decoded low address bits
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;   // nonsequential transfer
  localparam logic [2:0] HSIZE_WORD    = 3'h2;   // 32-bit access
  localparam logic       HRESP_OKAY    = 1'h0;   // okay response

  // ==========================================================================
  // register byte addresses
  localparam logic [7:0] A_FEATURE = 8'h00;  // feature_subcommand
  localparam logic [7:0] A_CNT_LO  = 8'h04;  // block_count_low
  localparam logic [7:0] A_CNT_HI  = 8'h08;  // block_count_high
  localparam logic [7:0] A_SEG_LO  = 8'h0C;  // segment_offset_low
  localparam logic [7:0] A_SEG_HI  = 8'h10;  // segment_offset_high
  localparam logic [7:0] A_DRIVE   = 8'h14;  // drive_select
  localparam logic [7:0] A_COMMAND = 8'h18;  // command_code
  localparam logic [7:0] A_ERROR   = 8'h1C;  // error_flags
  localparam logic [7:0] A_STATUS  = 8'h20;  // status_flags
  localparam logic [7:0] A_CONTROL = 8'h24;  // lock, spin-up disable, soft reset
  localparam logic [7:0] A_EXPECT  = 8'h28;  // expected next segment offset

  // ==========================================================================
  // field positions and values
  localparam int         ERR_UNC_BIT     = 6;      // uncorrectable_flag
  localparam int         ERR_ABT_BIT     = 2;      // command_aborted_flag
  localparam int         ST_ERR_BIT      = 0;      // status error bit
  localparam int         CTL_LOCK_BIT    = 0;      // security locked
  localparam int         CTL_SPINOFF_BIT = 1;      // spin-up disabled
  localparam int         CTL_SRST_BIT    = 2;      // soft reset, self clearing
  localparam int         ENG_RELOAD_BIT  = 0;      // image asks for reload
  localparam logic [7:0] TF_RESET        = 8'h00;  // task file reset value
  localparam logic [7:0] ST_READY        = 8'h50;  // ready and seek complete
  localparam logic [7:0] ST_BUSY         = 8'h80;  // busy

  // ==========================================================================
  // engine operations and sequencer states
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_XFER     = 3'b001,
    OP_VERIFY   = 3'b010,
    OP_SAVE     = 3'b011,
    OP_RELOAD   = 3'b100,
    OP_SPINDOWN = 3'b101,
    OP_DIAG     = 3'b110
  } fwdl_op_e;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_XFER   = 3'b001,
    S_VERIFY = 3'b010,
    S_SAVE   = 3'b011,
    S_RELOAD = 3'b100,
    S_SPIN   = 3'b101,
    S_DIAG   = 3'b110
  } fwdl_state_e;

endpackage

/* hw/fwdl_seg_track.sv */
// expected next segment offset tracker for segmented downloads
`timescale 1ns/1ns
module fwdl_seg_track #(
  parameter int OFS_W = 16
) (
  input  wire logic             clk,         // block clock
  input  wire logic             rst,         // async reset, active high
  input  wire logic             clear,       // drop gathered segments
  input  wire logic             advance,     // segment accepted
  input  wire logic [OFS_W-1:0] seg_offset,  // offset of current command
  input  wire logic [OFS_W-1:0] seg_count,   // block count of current command
  output logic      [OFS_W-1:0] expect_q,    // offset the next segment must carry
  output logic                  active_q,    // segments gathered so far
  output logic                  mismatch     // current offset out of sequence
);

  // ==========================================================================
  // expected offset, previous offset plus previous count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      expect_q <= '0;
      active_q <= 1'b0;
    end else if (clear) begin
      expect_q <= '0;
      active_q <= 1'b0;
    end else if (advance) begin
      expect_q <= seg_offset + seg_count;
      active_q <= 1'b1;
    end
  end

  // first segment must start at zero, later ones at the expected offset
  assign mismatch = active_q ? (seg_offset != expect_q) : (seg_offset != '0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  expect_clear_a: assert property (clear |=> (expect_q == '0) && !active_q)
    else $error("expected offset not cleared");
  expect_step_a: assert property (advance && !clear |=> expect_q == $past(seg_offset) + $past(seg_count))
    else $error("expected offset not advanced by count");

endmodule

/* hw/fwdl_cmd.sv */
// firmware download and self diagnostic command sequencer with ahb-lite task file
`timescale 1ns/1ns
module fwdl_cmd
  import fwdl_pkg::*;
(
  input  wire logic                CLOCK,            // 100 mhz clock
  input  wire logic                RST,              // async reset, active high
  input  wire logic                HSEL,             // slave select
  input  wire logic [31:0]         HADDR,            // byte address
  input  wire logic [1:0]          HTRANS,           // transfer type
  input  wire logic                HWRITE,           // write when high
  input  wire logic [2:0]          HSIZE,            // transfer size
  input  wire logic [31:0]         HWDATA,           // write data
  input  wire logic                HREADY,           // bus ready
  output logic      [31:0]         HRDATA,           // read data
  output logic                     HREADYOUT,        // slave ready
  output logic                     HRESP,            // always okay
  output logic                     ENG_REQ,          // engine operation request
  output fwdl_pkg::fwdl_op_e       ENG_OP,           // requested operation
  output logic      [15:0]         ENG_XFER_COUNT,   // sectors to move
  output logic      [15:0]         ENG_XFER_OFFSET,  // image start in sectors
  input  wire logic                ENG_DONE,         // operation finished, pulse
  input  wire logic                ENG_OK,           // operation succeeded
  input  wire logic                ENG_LAST,         // transfer held final segment
  input  wire logic [7:0]          ENG_CODE,         // reload wish or diagnostic code
  output logic                     DISCARD,          // drop partial image, pulse
  output logic                     BUSY              // command in progress
);

  // ==========================================================================
  // bus address phase capture
  logic                  acc;
  logic                  wr_pend_q;
  logic [ADDR_DEC_W-1:0] wr_addr_q;
  logic [31:0]           rdata_q;

  assign acc = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HSIZE == HSIZE_WORD)
               && (HADDR[31:ADDR_DEC_W] == '0);

  // task file, control and state
  logic [7:0]    feature_q;
  logic [7:0]    cnt_lo_q;
  logic [7:0]    cnt_hi_q;
  logic [7:0]    seg_lo_q;
  logic [7:0]    seg_hi_q;
  logic [7:0]    drive_q;
  logic [7:0]    error_q;
  logic [7:0]    status_q;
  logic          lock_q;
  logic          spin_off_q;
  logic          reload_want_q;
  fwdl_state_e   state_q;
  logic          eng_req_q;
  fwdl_op_e      eng_op_q;
  logic [15:0]   xfer_cnt_q;
  logic [15:0]   xfer_ofs_q;
  logic          discard_q;

  // decoded data phase writes
  logic        wr_now;
  logic        cmd_wr;
  logic        srst;
  logic        cmd_go;
  logic [7:0]  cmd_code;
  logic [15:0] blk_count;
  logic [15:0] seg_offset;
  logic        sub_ok;
  logic        seg_active;
  logic        seg_mismatch;
  logic [15:0] seg_expect;
  logic        dl_reject;
  logic        dl_seq_bad;
  logic        discard_now;
  logic        seg_clear;
  logic        seg_adv;
  logic        final_seg;
  logic [15:0] trk_offset;

  assign wr_now     = wr_pend_q;
  assign cmd_wr     = wr_now && (wr_addr_q == A_COMMAND);
  assign srst       = wr_now && (wr_addr_q == A_CONTROL) && HWDATA[CTL_SRST_BIT];
  assign cmd_code   = HWDATA[7:0];
  assign cmd_go     = cmd_wr && (state_q == S_IDLE) && !srst;
  assign blk_count  = {cnt_hi_q, cnt_lo_q};
  assign seg_offset = {seg_hi_q, seg_lo_q};
  assign sub_ok     = (feature_q == SUB_OFFSETS) || (feature_q == SUB_SINGLE);

  // lock or reserved subcommand rejects the download outright
  assign dl_reject  = lock_q || !sub_ok;
  assign dl_seq_bad = (feature_q == SUB_OFFSETS) && seg_mismatch;
  assign final_seg  = (state_q == S_XFER) && ENG_DONE && ((feature_q == SUB_SINGLE) || ENG_LAST);

  // ==========================================================================
  // when gathered segments are dropped or the tracker is cleared
  always_comb begin
    discard_now = 1'b0;
    if (srst && seg_active) begin
      discard_now = 1'b1;
    end else if (cmd_go && seg_active && !((cmd_code == CMD_DL_DMA) && (feature_q == SUB_OFFSETS))) begin
      discard_now = 1'b1;
    end else if (cmd_go && (cmd_code == CMD_DL_DMA) && seg_active && (dl_reject || dl_seq_bad)) begin
      discard_now = 1'b1;
    end
  end

  assign seg_clear = discard_now || srst || final_seg;
  assign seg_adv   = (state_q == S_XFER) && ENG_DONE && !final_seg;

  // while idle the tracker checks the new task-file offset, while moving it steps by the committed one
  assign trk_offset = (state_q == S_IDLE) ? seg_offset : xfer_ofs_q;

  // ==========================================================================
  // expected offset tracker
  fwdl_seg_track #(
    .OFS_W (16)
  ) u_track (
    .clk        (CLOCK),
    .rst        (RST),
    .clear      (seg_clear),
    .advance    (seg_adv),
    .seg_offset (trk_offset),
    .seg_count  (xfer_cnt_q),
    .expect_q   (seg_expect),
    .active_q   (seg_active),
    .mismatch   (seg_mismatch)
  );

  // ==========================================================================
  // ahb-lite slave: zero wait states, read data registered in the address phase
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q   <= '0;
    end else begin
      wr_pend_q <= acc && HWRITE;
      wr_addr_q <= HADDR[ADDR_DEC_W-1:0];
      rdata_q   <= '0;  // unmapped and write-only words read zero
      if (acc && !HWRITE) begin
        case (HADDR[ADDR_DEC_W-1:0])
          A_CNT_LO:  rdata_q[7:0]  <= cnt_lo_q;
          A_CNT_HI:  rdata_q[7:0]  <= cnt_hi_q;
          A_SEG_LO:  rdata_q[7:0]  <= seg_lo_q;
          A_SEG_HI:  rdata_q[7:0]  <= seg_hi_q;
          A_DRIVE:   rdata_q[7:0]  <= drive_q;
          A_ERROR:   rdata_q[7:0]  <= error_q;
          A_STATUS:  rdata_q[7:0]  <= status_q;
          A_CONTROL: begin
            rdata_q[CTL_LOCK_BIT]    <= lock_q;
            rdata_q[CTL_SPINOFF_BIT] <= spin_off_q;
          end
          A_EXPECT:  rdata_q[15:0] <= seg_expect;
          default:   rdata_q       <= '0;
        endcase
      end
    end
  end

  assign HRDATA    = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP     = HRESP_OKAY;

  // ==========================================================================
  // task file writes, ignored while busy; soft reset clears them
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      feature_q <= TF_RESET;
      cnt_lo_q  <= TF_RESET;
      cnt_hi_q  <= TF_RESET;
      seg_lo_q  <= TF_RESET;
      seg_hi_q  <= TF_RESET;
      drive_q   <= TF_RESET;
    end else if (srst) begin
      feature_q <= TF_RESET;
      cnt_lo_q  <= TF_RESET;
      cnt_hi_q  <= TF_RESET;
      seg_lo_q  <= TF_RESET;
      seg_hi_q  <= TF_RESET;
      drive_q   <= TF_RESET;
    end else if (wr_now && (state_q == S_IDLE)) begin
      case (wr_addr_q)
        A_FEATURE: feature_q <= HWDATA[7:0];
        A_CNT_LO:  cnt_lo_q  <= HWDATA[7:0];
        A_CNT_HI:  cnt_hi_q  <= HWDATA[7:0];
        A_SEG_LO:  seg_lo_q  <= HWDATA[7:0];
        A_SEG_HI:  seg_hi_q  <= HWDATA[7:0];
        A_DRIVE:   drive_q   <= HWDATA[7:0];
        default:   drive_q   <= drive_q;
      endcase
    end
  end

  // control register: security lock and spin-up disable
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      lock_q     <= 1'b0;
      spin_off_q <= 1'b0;
    end else if (wr_now && (wr_addr_q == A_CONTROL)) begin
      lock_q     <= HWDATA[CTL_LOCK_BIT];
      spin_off_q <= HWDATA[CTL_SPINOFF_BIT];
    end
  end

  // discard pulse toward the image buffer
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      discard_q <= 1'b0;
    end else begin
      discard_q <= discard_now;
    end
  end

  // ==========================================================================
  // command sequencer
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q       <= S_IDLE;
      eng_req_q     <= 1'b0;
      eng_op_q      <= OP_NONE;
      xfer_cnt_q    <= '0;
      xfer_ofs_q    <= '0;
      reload_want_q <= 1'b0;
      error_q       <= '0;
      status_q      <= ST_READY;
    end else if (srst) begin
      state_q       <= S_IDLE;
      eng_req_q     <= 1'b0;
      eng_op_q      <= OP_NONE;
      reload_want_q <= 1'b0;
      error_q       <= '0;
      status_q      <= ST_READY;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_go) begin
            error_q  <= '0;
            status_q <= ST_BUSY;
            if (cmd_code == CMD_DL_DMA) begin
              if (dl_reject || dl_seq_bad) begin
                error_q[ERR_ABT_BIT] <= 1'b1;
                status_q             <= ST_READY | 8'h01;
              end else if (blk_count == '0) begin
                status_q <= ST_READY;
              end else begin
                state_q    <= S_XFER;
                eng_req_q  <= 1'b1;
                eng_op_q   <= OP_XFER;
                xfer_cnt_q <= blk_count;
                xfer_ofs_q <= (feature_q == SUB_OFFSETS) ? seg_offset : '0;
              end
            end else if (cmd_code == CMD_SELF_DIAG) begin
              state_q   <= S_DIAG;
              eng_req_q <= 1'b1;
              eng_op_q  <= OP_DIAG;
            end else begin
              error_q[ERR_ABT_BIT] <= 1'b1;
              status_q             <= ST_READY | 8'h01;
            end
          end
        end
        S_XFER: begin
          if (ENG_DONE) begin
            if (final_seg) begin
              reload_want_q <= ENG_CODE[ENG_RELOAD_BIT];
              state_q       <= S_VERIFY;
              eng_op_q      <= OP_VERIFY;
            end else begin
              state_q   <= S_IDLE;
              eng_req_q <= 1'b0;
              eng_op_q  <= OP_NONE;
              status_q  <= ST_READY;
            end
          end
        end
        S_VERIFY: begin
          if (ENG_DONE) begin
            if (ENG_OK) begin
              state_q  <= S_SAVE;
              eng_op_q <= OP_SAVE;
            end else begin
              state_q              <= S_IDLE;
              eng_req_q            <= 1'b0;
              eng_op_q             <= OP_NONE;
              error_q[ERR_ABT_BIT] <= 1'b1;
              status_q             <= ST_READY | 8'h01;
            end
          end
        end
        S_SAVE: begin
          if (ENG_DONE) begin
            if (reload_want_q) begin
              state_q  <= S_RELOAD;
              eng_op_q <= OP_RELOAD;
            end else begin
              state_q   <= S_IDLE;
              eng_req_q <= 1'b0;
              eng_op_q  <= OP_NONE;
              status_q  <= ST_READY;
            end
          end
        end
        S_RELOAD: begin
          if (ENG_DONE) begin
            if (ENG_OK && spin_off_q) begin
              state_q  <= S_SPIN;
              eng_op_q <= OP_SPINDOWN;
            end else begin
              state_q              <= S_IDLE;
              eng_req_q            <= 1'b0;
              eng_op_q             <= OP_NONE;
              error_q[ERR_UNC_BIT] <= !ENG_OK;
              status_q             <= ENG_OK ? ST_READY : (ST_READY | 8'h01);
            end
          end
        end
        S_SPIN: begin
          if (ENG_DONE) begin
            state_q   <= S_IDLE;
            eng_req_q <= 1'b0;
            eng_op_q  <= OP_NONE;
            status_q  <= ST_READY;
          end
        end
        S_DIAG: begin
          if (ENG_DONE) begin
            state_q   <= S_IDLE;
            eng_req_q <= 1'b0;
            eng_op_q  <= OP_NONE;
            error_q   <= ENG_CODE;
            status_q  <= ST_READY;
          end
        end
        default: begin
          state_q   <= S_IDLE;
          eng_req_q <= 1'b0;
          eng_op_q  <= OP_NONE;
        end
      endcase
    end
  end

  assign ENG_REQ         = eng_req_q;
  assign ENG_OP          = eng_op_q;
  assign ENG_XFER_COUNT  = xfer_cnt_q;
  assign ENG_XFER_OFFSET = xfer_ofs_q;
  assign DISCARD         = discard_q;
  assign BUSY            = status_q[7];

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  dl_start_a: assert property (cmd_go && (cmd_code == CMD_DL_DMA) && !dl_reject && !dl_seq_bad
                               && (blk_count != '0) |=> ENG_REQ && (ENG_OP == OP_XFER) && BUSY)
    else $error("download did not start a transfer");
  sub_abort_a: assert property (cmd_go && (cmd_code == CMD_DL_DMA) && dl_reject
                                |=> error_q[ERR_ABT_BIT] && (state_q == S_IDLE) && !ENG_REQ)
    else $error("reserved subcommand or lock not aborted");
  count_form_a: assert property (state_q == S_XFER |-> ENG_XFER_COUNT == {cnt_hi_q, cnt_lo_q})
    else $error("transfer count not formed from count bytes");
  zero_count_a: assert property (cmd_go && (cmd_code == CMD_DL_DMA) && !dl_reject && !dl_seq_bad
                                 && (blk_count == '0) |=> !ENG_REQ && (status_q == ST_READY))
    else $error("zero count moved data");
  offset_take_a: assert property (cmd_go && (cmd_code == CMD_DL_DMA) && !dl_reject && !dl_seq_bad
                                  && (blk_count != '0) |=> ENG_XFER_OFFSET == ((feature_q == SUB_OFFSETS)
                                  ? $past(seg_offset) : 16'h0000))
    else $error("segment offset not taken from offset bytes");
  seq_abort_a: assert property (cmd_go && (cmd_code == CMD_DL_DMA) && !dl_reject && dl_seq_bad
                                |=> error_q[ERR_ABT_BIT] && !ENG_REQ)
    else $error("out of sequence segment not aborted");
  unc_cause_a: assert property ($rose(error_q[ERR_UNC_BIT]) && ($past(state_q) != S_DIAG)
                                |-> $past(state_q) == S_RELOAD)
    else $error("uncorrectable set outside a failed reload");
  spin_down_a: assert property ((state_q == S_RELOAD) && ENG_DONE && ENG_OK && spin_off_q
                                |=> ENG_REQ && (ENG_OP == OP_SPINDOWN))
    else $error("no spin down after reload");
  verify_save_a: assert property ((state_q == S_VERIFY) && ENG_DONE && ENG_OK
                                  |=> ENG_OP == OP_SAVE ##0 ENG_REQ)
    else $error("verified image not saved");
  other_drop_a: assert property (cmd_go && (cmd_code != CMD_DL_DMA) && seg_active
                                 |=> DISCARD && !seg_active)
    else $error("segments kept across another command");
  done_status_a: assert property ($fell(BUSY) |-> status_q[7:2] == ST_READY[7:2])
    else $error("completion status bits wrong");
  diag_code_a: assert property ((state_q == S_DIAG) && ENG_DONE |=> error_q == $past(ENG_CODE))
    else $error("diagnostic code not in error register");

endmodule

/* testbench/fwdl_eng_model.sv */
// engine model that answers the operation requests of the command block
`timescale 1ns/1ns
module fwdl_eng_model
  import fwdl_pkg::*;
(
  input  wire logic               clk,      // block clock
  input  wire logic               rst,      // async reset
  input  wire logic               req,      // operation request
  input  wire fwdl_pkg::fwdl_op_e op,       // requested operation
  input  wire logic               rl_ok,    // reload succeeds
  input  wire logic               last_in,  // transfer holds final segment
  input  wire logic [7:0]         code_in,  // reload wish or diagnostic code
  output logic                    done,     // one-cycle finish pulse
  output logic                    ok,       // success, valid with done
  output logic                    last,     // final segment, valid with done
  output logic      [7:0]         code      // code, valid with done
);
  import fwdl_pkg::*;
  logic [3:0] cnt_q;
  // ==========================================================================
  // finish each operation four cycles after it is requested, for any sector count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      done  <= 1'b0;
    end else begin
      done  <= req && !done && cnt_q == 4'h3;
      cnt_q <= (req && !done && cnt_q != 4'h3) ? cnt_q + 4'h1 : 4'h0;
    end
  end
  // answers are inverted outside the done cycle
  assign ok   = (op != OP_RELOAD || rl_ok) ^ !done;
  assign last = last_in ^ !done;
  assign code = done ? code_in : ~code_in;
endmodule

/* testbench/fwdl_cmd_tb.sv */
// self-checking bench for the firmware download and diagnostic command block
`timescale 1ns/1ns
`define CK(g,e,m) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %0t %s", $time, m); end end
module fwdl_cmd_tb;
  import fwdl_pkg::*;
  logic CLOCK = 0, RST = 1, hsel = 0, hwrite = 0, rl_ok = 1, last_in = 0, spin = 0, drop = 0;
  logic hready, req, done, ok, last, disc, busy;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [7:0] code_in = 0, code;
  logic [15:0] xcnt, xofs;
  fwdl_op_e op;
  int miscompares = 0, cmp_count = 0;
  fwdl_cmd DUT (.CLOCK(CLOCK), .RST(RST), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(HSIZE_WORD), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
    .ENG_REQ(req), .ENG_OP(op), .ENG_XFER_COUNT(xcnt), .ENG_XFER_OFFSET(xofs), .ENG_DONE(done),
    .ENG_OK(ok), .ENG_LAST(last), .ENG_CODE(code), .DISCARD(disc), .BUSY(busy));
  fwdl_eng_model ENG (.clk(CLOCK), .rst(RST), .req(req), .op(op), .rl_ok(rl_ok), .last_in(last_in),
    .code_in(code_in), .done(done), .ok(ok), .last(last), .code(code));
  // ==========================================================================
  // clock and sticky event flags
  initial forever #5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    if (req && op == OP_SPINDOWN) spin <= 1;
    if (disc) drop <= 1;
  end
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for ready, then for busy to fall
  task hw;
    int i;
    i = 0;
    do begin @(posedge CLOCK); i++; end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) begin miscompares++; end_of_test; end
  endtask
  task idle;
    int i;
    @(posedge CLOCK);
    for (i = 0; i < 99 && busy !== 1'b0; i++) @(posedge CLOCK);
    if (busy !== 1'b0) begin miscompares++; end_of_test; end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    hsel <= 1; htrans <= HTRANS_NONSEQ; hwrite <= 1; haddr <= {24'h0, a};
    hw;
    htrans <= 0; hsel <= 0; hwdata <= {24'h0, d};
    hw;
  endtask
  task chk(input logic [7:0] a, input logic [31:0] e);
    hsel <= 1; htrans <= HTRANS_NONSEQ; hwrite <= 0; haddr <= {24'h0, a};
    hw;
    htrans <= 0; hsel <= 0;
    hw;
    r = hrdata;
    `CK(r, e, "register value")
  endtask
  task cmd(input logic [7:0] f, ch, cl, oh, ol, c);
    wr(A_FEATURE, f); wr(A_CNT_HI, ch); wr(A_CNT_LO, cl); wr(A_SEG_HI, oh); wr(A_SEG_LO, ol); wr(A_COMMAND, c);
  endtask
  // ==========================================================================
  // scenarios
  task t_abort;
    chk(A_STATUS, 32'h50);
    cmd(8'h05, 0, 1, 0, 0, CMD_DL_DMA); idle;
    chk(A_ERROR, 32'h04);
    chk(A_STATUS, 32'h51);
    wr(A_CONTROL, 1); cmd(SUB_SINGLE, 0, 1, 0, 0, CMD_DL_DMA); idle;
    chk(A_ERROR, 32'h04);
    $display("abort test done");
  endtask
  task t_seg;
    wr(A_CONTROL, 0); cmd(SUB_OFFSETS, 0, 4, 0, 0, CMD_DL_DMA);
    @(posedge CLOCK); #1;
    `CK(op, OP_XFER, "operation")
    `CK(xcnt, 16'h0004, "count")
    idle; chk(A_EXPECT, 32'h4);
    cmd(SUB_OFFSETS, 0, 2, 0, 4, CMD_DL_DMA); @(posedge CLOCK); #1;
    `CK(xofs, 16'h0004, "segment offset")
    idle; chk(A_EXPECT, 32'h6);
    cmd(SUB_OFFSETS, 0, 2, 0, 9, CMD_DL_DMA); idle;
    chk(A_ERROR, 32'h04);
    chk(A_EXPECT, 32'h0);
    cmd(SUB_OFFSETS, 0, 4, 0, 0, CMD_DL_DMA); idle; drop <= 0; code_in <= 8'h81;
    cmd(0, 0, 0, 0, 0, CMD_SELF_DIAG); idle;
    `CK(drop, 1'b1, "segments dropped")
    chk(A_ERROR, 32'h81);
    chk(A_STATUS, 32'h50);
    $display("segment test done");
  endtask
  task t_final;
    cmd(SUB_SINGLE, 0, 0, 0, 0, CMD_DL_DMA); @(posedge CLOCK); #1;
    `CK(req, 1'b0, "no transfer")
    cmd(SUB_OFFSETS, 0, 4, 0, 0, CMD_DL_DMA); idle; drop <= 0;
    wr(A_CONTROL, 4); chk(A_EXPECT, 32'h0);
    `CK(drop, 1'b1, "soft reset drop")
    drop <= 0; cmd(SUB_OFFSETS, 0, 4, 0, 0, CMD_DL_DMA); idle; last_in <= 1;
    cmd(SUB_OFFSETS, 0, 1, 0, 4, CMD_DL_DMA); idle; last_in <= 0;
    chk(A_EXPECT, 32'h0);
    chk(A_STATUS, 32'h50);
    `CK(drop, 1'b0, "image kept on completion")
    cmd(SUB_OFFSETS, 0, 4, 0, 0, CMD_DL_DMA); idle;
    RST <= 1; @(posedge CLOCK); RST <= 0; @(posedge CLOCK);
    chk(A_EXPECT, 32'h0);
    chk(A_STATUS, 32'h50);
    for (int k = 0; k < 2; k++) begin
      wr(A_CONTROL, 2); rl_ok <= k[0]; code_in <= 1; spin <= 0;
      cmd(SUB_SINGLE, 8'h01, 8'h02, 8'h55, 8'h55, CMD_DL_DMA); @(posedge CLOCK); #1;
      `CK(xcnt, 16'h0102, "count")
      `CK(xofs, 16'h0, "offset")
      idle; chk(A_ERROR, k ? 32'h0 : 32'h40);
      chk(A_STATUS, k ? 32'h50 : 32'h51);
      if (k) `CK(spin, 1'b1, "spin down")
    end
    $display("final test done");
  endtask
  initial begin
    repeat (2) @(posedge CLOCK);
    RST <= 0;
    @(posedge CLOCK);
    t_abort; t_seg; t_final;
    end_of_test;
  end
endmodule
